// ### pkg/emb_pkg.sv
// package: constants and types of the external memory bus interface
package emb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W          = 16;
  localparam int DATA_W          = 8;
  localparam int PROG_INT_BYTES  = 32768;
  localparam int IDATA_BYTES     = 512;
  localparam int AUX_BYTES       = 256;

  localparam logic [15:0] PROG_INT_LIMIT = 16'h8000;
  localparam logic [15:0] AUX_LIMIT      = 16'h0100;

  ////////////////////////////////////////////////////////////////////////////
  // slot timing, in oscillator periods
  localparam int            SLOT_OSC       = 6;
  localparam logic [2:0]    SLOT_LAST      = 3'h5;
  localparam logic [2:0]    ALE_HIGH_END   = 3'h2;
  localparam logic [2:0]    ADDR_DRIVE_END = 3'h3;
  localparam logic [2:0]    FETCH_STRB_BEG = 3'h3;
  localparam logic [2:0]    DATA_STRB_BEG  = 3'h1;
  localparam logic [2:0]    DATA_STRB_END  = 3'h4;
  localparam int            OSC_DIV_DEF    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // request spaces
  localparam logic [1:0] SPACE_CODE  = 2'h0;
  localparam logic [1:0] SPACE_XDATA = 2'h1;
  localparam logic [1:0] SPACE_IDATA = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] HIGH_ADDR_RST = 8'hff;
  localparam logic [7:0] LOW_PORT_RST  = 8'hff;

  typedef enum logic [2:0] {
    EMB_IDLE  = 3'h0,
    EMB_INT   = 3'h1,
    EMB_IRESP = 3'h3,
    EMB_WAIT  = 3'h2,
    EMB_FETCH = 3'h6,
    EMB_DADDR = 3'h7,
    EMB_DXFER = 3'h5
  } emb_state_type;

endpackage : emb_pkg

// ### rtl/emb_int_mem.sv
// internal program memory and internal data memory (main and auxiliary)
`timescale 1ns/100ps
module emb_int_mem
  import emb_pkg::*;
#(
  parameter int PROG_BYTES  = PROG_INT_BYTES,
  parameter int IDATA_TOTAL = IDATA_BYTES
)(
  input  wire logic        sys_clk_i,
  input  wire logic        load_en_i,
  input  wire logic [14:0] load_addr_i,
  input  wire logic [7:0]  load_data_i,
  input  wire logic        prog_rd_i,
  input  wire logic [14:0] prog_addr_i,
  input  wire logic        data_en_i,
  input  wire logic        data_we_i,
  input  wire logic [8:0]  data_addr_i,
  input  wire logic [7:0]  data_wdata_i,
  output logic      [7:0]  rdata_o
);

  logic [7:0] prog_mem  [PROG_BYTES];
  logic [7:0] idata_mem [IDATA_TOTAL];

  ////////////////////////////////////////////////////////////////////////////
  // program store, loaded from outside
  always_ff @(posedge sys_clk_i)
  begin
    if (load_en_i)
    begin
      prog_mem[load_addr_i] <= load_data_i;
    end
  end

  // main ram in lower half, auxiliary ram in upper half
  always_ff @(posedge sys_clk_i)
  begin
    if (data_en_i && data_we_i)
    begin
      idata_mem[data_addr_i] <= data_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (prog_rd_i)
    begin
      rdata_o <= prog_mem[prog_addr_i];
    end
    else if (data_en_i)
    begin
      rdata_o <= idata_mem[data_addr_i];
    end
  end

endmodule : emb_int_mem

// ### rtl/emb_bus.sv
// external memory bus interface: fetch, data access, multiplexed bus pins
`timescale 1ns/100ps

// Contract
// - address strobe every six oscillator periods
// - skip one strobe per external data access
// - access select latched during reset only
// - low port carries address then data
// - high port drives high address byte
// - read/write strobes only in data cycles
// - 32k internal code, 64k external range
// - 512 bytes internal main plus auxiliary
// - lowest 256 data bytes stay internal
// - active-low fetch strobe reads external code
// - address valid at strobe; partner latches it
// - access select steers internal/external fetches
// - internal accesses leave bus pins untouched
module emb_bus
  import emb_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEF
)(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        external_access_select_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_space_i,
  input  wire logic        req_write_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  output logic             req_ready_o,
  output logic             resp_valid_o,
  output logic      [7:0]  resp_data_o,
  input  wire logic        prog_load_en_i,
  input  wire logic [14:0] prog_load_addr_i,
  input  wire logic [7:0]  prog_load_data_i,
  output logic             addr_latch_strobe_o,
  output logic             program_fetch_strobe_n_o,
  output logic             xdata_read_strobe_n_o,
  output logic             xdata_write_strobe_n_o,
  output logic      [7:0]  high_addr_port_o,
  input  wire logic [7:0]  low_addr_data_port_i,
  output logic      [7:0]  low_addr_data_port_o,
  output logic             low_addr_data_port_oe_o
);

  emb_state_type state;
  emb_state_type next_state;

  logic [15:0] cur_addr;
  logic [7:0]  cur_wdata;
  logic [1:0]  cur_space;
  logic        cur_write;
  logic        ea_latched;
  logic [2:0]  phase;
  logic [15:0] div_cnt;
  logic [7:0]  mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator period enable and six-period slot counter
  wire osc_tick = (div_cnt == 16'(OSC_DIV - 1));
  wire slot_end = osc_tick && (phase == SLOT_LAST);

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || osc_tick)
    begin
      div_cnt <= 16'h0000;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || slot_end)
    begin
      phase <= 3'h0;
    end
    else if (osc_tick)
    begin
      phase <= phase + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access select caught while reset is held, frozen afterwards
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ea_latched <= external_access_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing of a request: internal store or external bus
  function automatic logic is_internal(input logic [1:0] space, input logic [15:0] addr,
                                      input logic ea);
    logic r;
    r = 1'b0;
    if (space == SPACE_IDATA)
    begin
      r = 1'b1;
    end
    else if (space == SPACE_XDATA)
    begin
      r = (addr < AUX_LIMIT);
    end
    else
    begin
      r = ea && (addr < PROG_INT_LIMIT);
    end
    return r;
  endfunction : is_internal

  wire accept   = (state == EMB_IDLE) && req_valid_i && req_ready_o;
  wire acc_int  = is_internal(req_space_i, req_addr_i, ea_latched);
  wire cur_code = (cur_space != SPACE_XDATA) && (cur_space != SPACE_IDATA);

  always_comb
  begin
    next_state = state;
    case (state)
      EMB_IDLE:
        if (accept)
        begin
          next_state = acc_int ? EMB_INT : EMB_WAIT;
        end
      EMB_INT:
        next_state = EMB_IRESP;
      EMB_IRESP:
        next_state = EMB_IDLE;
      EMB_WAIT:
        if (slot_end)
        begin
          next_state = cur_code ? EMB_FETCH : EMB_DADDR;
        end
      EMB_FETCH:
        if (slot_end)
        begin
          next_state = EMB_IDLE;
        end
      EMB_DADDR:
        if (slot_end)
        begin
          next_state = EMB_DXFER;
        end
      EMB_DXFER:
        if (slot_end)
        begin
          next_state = EMB_IDLE;
        end
      default:
        next_state = EMB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state <= EMB_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      cur_addr  <= 16'h0000;
      cur_wdata <= 8'h00;
      cur_space <= SPACE_CODE;
      cur_write <= 1'b0;
    end
    else if (accept)
    begin
      cur_addr  <= req_addr_i;
      cur_wdata <= req_wdata_i;
      cur_space <= req_space_i;
      cur_write <= req_write_i && ((req_space_i == SPACE_XDATA) || (req_space_i == SPACE_IDATA));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal store
  wire       int_prog_rd = (state == EMB_INT) && cur_code;
  wire       int_data_en = (state == EMB_INT) && !cur_code;
  wire [8:0] int_data_a  = {cur_space == SPACE_XDATA, cur_addr[7:0]};

  emb_int_mem u_int_mem (
    .sys_clk_i    (sys_clk_i),
    .load_en_i    (prog_load_en_i),
    .load_addr_i  (prog_load_addr_i),
    .load_data_i  (prog_load_data_i),
    .prog_rd_i    (int_prog_rd),
    .prog_addr_i  (cur_addr[14:0]),
    .data_en_i    (int_data_en),
    .data_we_i    (cur_write),
    .data_addr_i  (int_data_a),
    .data_wdata_i (cur_wdata),
    .rdata_o      (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin decode; internal states never reach the pins
  wire in_fetch = (state == EMB_FETCH);
  wire in_daddr = (state == EMB_DADDR);
  wire in_dxfer = (state == EMB_DXFER);
  wire ext_bus  = in_fetch || in_daddr || in_dxfer;

  wire next_ale    = (phase < ALE_HIGH_END) && !in_dxfer;
  wire addr_phase  = (in_fetch || in_daddr) && (phase < ADDR_DRIVE_END);
  wire wdata_phase = in_dxfer && cur_write;
  wire strobe_win  = (phase >= DATA_STRB_BEG) && (phase <= DATA_STRB_END);
  wire next_fetch_n = !(in_fetch && (phase >= FETCH_STRB_BEG));
  wire next_rd_n    = !(in_dxfer && !cur_write && strobe_win);
  wire next_wr_n    = !(in_dxfer && cur_write && strobe_win);
  wire next_oe      = addr_phase || wdata_phase;
  wire [7:0] next_low  = addr_phase ? cur_addr[7:0] :
                         (wdata_phase ? cur_wdata : low_addr_data_port_o);
  wire [7:0] next_high = ext_bus ? cur_addr[15:8] : high_addr_port_o;

  wire ext_done  = slot_end && (in_fetch || in_dxfer);
  wire next_resp = (state == EMB_IRESP) || ext_done;
  wire [7:0] next_rdata = (state == EMB_IRESP) ? mem_rdata :
                          (cur_write ? 8'h00 : low_addr_data_port_i);

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      addr_latch_strobe_o      <= 1'b0;
      program_fetch_strobe_n_o <= 1'b1;
      xdata_read_strobe_n_o    <= 1'b1;
      xdata_write_strobe_n_o   <= 1'b1;
      low_addr_data_port_oe_o  <= 1'b0;
      low_addr_data_port_o     <= LOW_PORT_RST;
      high_addr_port_o         <= HIGH_ADDR_RST;
    end
    else
    begin
      addr_latch_strobe_o      <= next_ale;
      program_fetch_strobe_n_o <= next_fetch_n;
      xdata_read_strobe_n_o    <= next_rd_n;
      xdata_write_strobe_n_o   <= next_wr_n;
      low_addr_data_port_oe_o  <= next_oe;
      low_addr_data_port_o     <= next_low;
      high_addr_port_o         <= next_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request/answer port
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      req_ready_o  <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_data_o  <= 8'h00;
    end
    else
    begin
      req_ready_o  <= (next_state == EMB_IDLE);
      resp_valid_o <= next_resp;
      if (next_resp)
      begin
        resp_data_o <= next_rdata;
      end
    end
  end

endmodule : emb_bus

// ### verif/emb_bus_asserts.sv
// checker: pin timing of the external memory bus
`timescale 1ns/100ps
module emb_bus_asserts
#(
  parameter int OSC_DIV = 1
)(
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       req_valid_i,
  input wire logic [1:0] req_space_i,
  input wire logic [15:0] req_addr_i,
  input wire logic       req_ready_o,
  input wire logic       resp_valid_o,
  input wire logic       addr_latch_strobe_o,
  input wire logic       program_fetch_strobe_n_o,
  input wire logic       xdata_read_strobe_n_o,
  input wire logic       xdata_write_strobe_n_o,
  input wire logic [7:0] high_addr_port_o,
  input wire logic [7:0] low_addr_data_port_o,
  input wire logic       low_addr_data_port_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire take_int = req_valid_i && req_ready_o &&
                  (req_space_i == 2'h2 || (req_space_i == 2'h1 && req_addr_i[15:8] == 8'h00));
  wire dstrb = !xdata_read_strobe_n_o || !xdata_write_strobe_n_o;
  wire quiet = program_fetch_strobe_n_o && !dstrb && !low_addr_data_port_oe_o;
  strobe_width_a: assert property (
    $rose(addr_latch_strobe_o) |=> addr_latch_strobe_o ##1 !addr_latch_strobe_o [*4])
    else $error("address strobe width wrong");
  strobe_cadence_a: assert property (
    $fell(addr_latch_strobe_o) |-> ##5 (addr_latch_strobe_o || dstrb))
    else $error("address strobe cadence broken");
  skip_once_a: assert property (
    $rose(dstrb) |-> ##5 addr_latch_strobe_o)
    else $error("more than one strobe skipped");
  data_slot_a: assert property (
    dstrb |-> !addr_latch_strobe_o && program_fetch_strobe_n_o)
    else $error("data strobe outside data slot");
  fetch_slot_a: assert property (
    !program_fetch_strobe_n_o |-> !addr_latch_strobe_o && !dstrb && !low_addr_data_port_oe_o)
    else $error("fetch strobe with bus busy");
  addr_setup_a: assert property (
    $fell(addr_latch_strobe_o) && $past(low_addr_data_port_oe_o) |->
      low_addr_data_port_oe_o && $stable(low_addr_data_port_o) && $stable(high_addr_port_o))
    else $error("address not held at strobe fall");
  data_dir_a: assert property (
    dstrb |-> low_addr_data_port_oe_o == !xdata_write_strobe_n_o)
    else $error("port direction wrong in data phase");
  internal_quiet_a: assert property (
    take_int |=> (quiet && $stable(high_addr_port_o)) [*2] ##1 (quiet && resp_valid_o))
    else $error("internal access moved pins");
  cover property (!program_fetch_strobe_n_o);
  cover property (!xdata_read_strobe_n_o);
  cover property (!xdata_write_strobe_n_o);
endmodule : emb_bus_asserts
bind emb_bus emb_bus_asserts #(.OSC_DIV(OSC_DIV)) u_chk (.sys_clk_i, .reset_i,
  .req_valid_i, .req_space_i, .req_addr_i, .req_ready_o, .resp_valid_o, .addr_latch_strobe_o,
  .program_fetch_strobe_n_o, .xdata_read_strobe_n_o, .xdata_write_strobe_n_o,
  .high_addr_port_o, .low_addr_data_port_o, .low_addr_data_port_oe_o);

// ### verif/emb_ext_mem.sv
// partner: external code and data memory on the multiplexed bus
`timescale 1ns/100ps
module emb_ext_mem
(
  input  wire logic        sys_clk_i,
  input  wire logic        strobe_i,
  input  wire logic        fetch_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  high_i,
  input  wire logic [7:0]  bus_out_i,
  input  wire logic        bus_oe_i,
  output logic      [7:0]  bus_in_o,
  output logic      [15:0] last_addr_o
);
  logic [7:0] mem [65536];
  logic [65535:0] written = '0;
  logic [7:0] rdata;
  logic [7:0] last = 8'h00;
  logic       strobe_q = 1'b0;
  logic       wr_q = 1'b1;
  always @(posedge sys_clk_i)
  begin
    strobe_q <= strobe_i;
    wr_q <= wr_n_i;
    last <= bus_in_o;
    if (strobe_q && !strobe_i)
      last_addr_o <= {high_i, bus_out_i};
    if (!wr_q && wr_n_i)
    begin
      mem[last_addr_o]     <= bus_out_i;
      written[last_addr_o] <= 1'b1;
    end
  end
  assign rdata = written[last_addr_o] ? mem[last_addr_o] : (last_addr_o[7:0] ^ last_addr_o[15:8]);
  // released port outside fetch and read strobes shows a moving pattern, never the last value
  assign bus_in_o = bus_oe_i ? bus_out_i : (!fetch_n_i || !rd_n_i) ? rdata : ~last;
endmodule : emb_ext_mem

// ### verif/emb_bus_tb_top.sv
// testbench: request port and bus traffic of emb_bus
`timescale 1ns/100ps
module emb_bus_tb_top;
  import emb_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, external_access_select_i = 1'b1;
  logic req_valid_i = 1'b0, req_write_i = 1'b0, prog_load_en_i = 1'b0;
  logic [1:0] req_space_i = 2'h0;
  logic [15:0] req_addr_i = 16'h0000;
  logic [7:0] req_wdata_i = 8'h00, prog_load_data_i = 8'h00, rd;
  logic [14:0] prog_load_addr_i = 15'h0000;
  wire logic req_ready_o, resp_valid_o, addr_latch_strobe_o, program_fetch_strobe_n_o;
  wire logic xdata_read_strobe_n_o, xdata_write_strobe_n_o, low_addr_data_port_oe_o;
  wire logic [7:0] resp_data_o, high_addr_port_o, low_addr_data_port_i, low_addr_data_port_o;
  wire logic [15:0] last_addr;
  int err_count = 0;
  int comparisons = 0;
  emb_bus uut (.sys_clk_i, .reset_i, .external_access_select_i, .req_valid_i, .req_space_i,
    .req_write_i, .req_addr_i, .req_wdata_i, .req_ready_o, .resp_valid_o, .resp_data_o,
    .prog_load_en_i, .prog_load_addr_i, .prog_load_data_i, .addr_latch_strobe_o,
    .program_fetch_strobe_n_o, .xdata_read_strobe_n_o, .xdata_write_strobe_n_o,
    .high_addr_port_o, .low_addr_data_port_i, .low_addr_data_port_o, .low_addr_data_port_oe_o);
  emb_ext_mem ext (.sys_clk_i, .strobe_i(addr_latch_strobe_o), .fetch_n_i(program_fetch_strobe_n_o),
    .rd_n_i(xdata_read_strobe_n_o), .wr_n_i(xdata_write_strobe_n_o), .high_i(high_addr_port_o),
    .bus_out_i(low_addr_data_port_o), .bus_oe_i(low_addr_data_port_oe_o),
    .bus_in_o(low_addr_data_port_i), .last_addr_o(last_addr));
  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {8'h00, a[7:0] ^ a[15:8]};
  endfunction : pat
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic do_reset(input logic sel);
    reset_i = 1'b1;
    external_access_select_i = sel;
    repeat (4) @(negedge sys_clk_i);
    chk({8'h00, addr_latch_strobe_o, program_fetch_strobe_n_o, xdata_read_strobe_n_o,
         xdata_write_strobe_n_o, low_addr_data_port_oe_o, req_ready_o, resp_valid_o, 1'b0},
        16'h0070);
    chk({high_addr_port_o, low_addr_data_port_o}, {HIGH_ADDR_RST, LOW_PORT_RST});
    reset_i = 1'b0;
    external_access_select_i = ~sel;
  endtask : do_reset
  task automatic xfer(input logic [1:0] sp, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    int n;
    for (n = 0; n < 60 && req_ready_o !== 1'b1; n++)
      @(negedge sys_clk_i);
    if (req_ready_o !== 1'b1)
    begin
      err_count++;
      $display("unexpected at %0t: never ready", $time);
      end_sim();
    end
    {req_space_i, req_write_i, req_addr_i, req_wdata_i} = {sp, w, a, d};
    req_valid_i = 1'b1;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    for (n = 0; n < 60 && resp_valid_o !== 1'b1; n++)
      @(negedge sys_clk_i);
    if (resp_valid_o !== 1'b1)
    begin
      err_count++;
      $display("unexpected at %0t: no answer", $time);
      end_sim();
    end
    rd = resp_data_o;
  endtask : xfer
  task automatic scen_code();
    prog_load_en_i = 1'b1;
    {prog_load_addr_i, prog_load_data_i} = {15'h1234, 8'h77};
    @(negedge sys_clk_i);
    {prog_load_addr_i, prog_load_data_i} = {15'h7fff, 8'h66};
    @(negedge sys_clk_i);
    prog_load_en_i = 1'b0;
    xfer(2'h0, 1'b0, 16'h1234, 8'h00);
    chk({8'h00, rd}, 16'h0077);
    xfer(2'h0, 1'b0, 16'h7fff, 8'h00);
    chk({8'h00, rd}, 16'h0066);
    xfer(2'h0, 1'b0, 16'h8000, 8'h00);
    chk({8'h00, rd}, pat(16'h8000));
    chk(last_addr, 16'h8000);
  endtask : scen_code
  task automatic scen_data();
    xfer(2'h1, 1'b1, 16'h0050, 8'h3c);
    xfer(2'h1, 1'b1, 16'h1280, 8'ha5);
    xfer(2'h2, 1'b1, 16'h0050, 8'h5e);
    xfer(2'h1, 1'b0, 16'h0050, 8'h00);
    chk({8'h00, rd}, 16'h003c);
    xfer(2'h2, 1'b0, 16'h0050, 8'h00);
    chk({8'h00, rd}, 16'h005e);
    xfer(2'h1, 1'b0, 16'h1280, 8'h00);
    chk({8'h00, rd}, 16'h00a5);
    chk(last_addr, 16'h1280);
    xfer(2'h1, 1'b0, 16'h0100, 8'h00);
    chk({8'h00, rd}, pat(16'h0100));
  endtask : scen_data
  task automatic scen_select();
    do_reset(1'b0);
    xfer(2'h0, 1'b0, 16'h1234, 8'h00);
    chk({8'h00, rd}, pat(16'h1234));
    chk(last_addr, 16'h1234);
  endtask : scen_select
  initial
  begin
    do_reset(1'b1);
    scen_code();
    scen_data();
    scen_select();
    end_sim();
  end
endmodule : emb_bus_tb_top
